//--- design/osc_supply_defs.svh
`ifndef OSC_SUPPLY_DEFS_SVH
`define OSC_SUPPLY_DEFS_SVH

// register offsets
`define OSC_CTRL_ADDR      8'h25
`define SUPPLY_CTRL_ADDR   8'h26
`define FLAG_ADDR          8'h2b

// oscillator control fields
`define JITTER_BIT         4
`define DRIVE_MSB          3
`define DRIVE_LSB          2
`define LOAD_MSB           1
`define LOAD_LSB           0
`define OSC_CTRL_RESET     8'h00

// supply switch control fields
`define SW_DISABLE_BIT     4
`define SW_REFRESH_BIT     3
`define SW_CRIT_MSB        2
`define SW_CRIT_LSB        1
`define SW_THRESH_BIT      0
`define SUPPLY_CTRL_RESET  5'h00

// flag register field
`define SW_FLAG_BIT        0

// timing: interrupt pulse is one period of the slow clear clock
`define REF_CLK_HZ         125000000
`define IRQ_CLEAR_HZ       128
`define IRQ_PULSE_CYCLES   (`REF_CLK_HZ / `IRQ_CLEAR_HZ)

`endif

//--- design/osc_supply_pkg.sv
package osc_supply_pkg;

    // decoded crystal drive strength
    typedef enum logic [1:0] {
        DRIVE_NORMAL,
        DRIVE_LOW,
        DRIVE_HIGH
    } drive_type;

    // decoded load capacitance
    typedef enum logic [1:0] {
        LOAD_7P0,
        LOAD_6P0,
        LOAD_12P5
    } load_type;

    // whole state of the block
    typedef struct packed {
        logic [7:0]  oscCtrl;      // oscillator control byte
        logic [4:0]  supplyCtrl;   // supply switch control bits
        logic        switchFlag;   // sticky switch-over flag
        logic        battMeta;     // sync stage 1
        logic        battSync;     // sync stage 2
        logic        onBattery;    // synchronised supply state
        logic        tsInMeta;     // sync stage 1
        logic        tsInSync;     // sync stage 2
        logic        tsMechMeta;   // sync stage 1
        logic        tsMechSync;   // sync stage 2
        logic [19:0] pulseCnt;     // interrupt pulse timer
        logic [7:0]  rdData;       // read answer
        logic        rdValid;      // read answer strobe
        drive_type   drive;        // decoded drive
        load_type    load;         // decoded load
        logic        clkOut;       // clock pin level
        logic        clkOe;        // clock pin enable
        logic        tsOut;        // timestamp pin level
        logic        tsOe;         // timestamp pin enable
        logic        tsIn;         // gated digital input
        logic        tsMech;       // switch detector input
        logic        irqOe;        // first irq pin pulls low
    } state_type;

endpackage : osc_supply_pkg

//--- design/osc_and_supply_switch_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "osc_supply_defs.svh"

// Contract
// - bit 4 selects reduced clock jitter
// - drive field: 00 normal, 01 low, 1x high
// - load field: 00 7.0, 01 6.0, 1x 12.5pF
// - flag set on each switch to battery
// - flag readable only on main supply
// - battery switch gives pulse or low level
// - pulse also on return to main
// - battery: ignore serial clock and data
// - battery: clock pin disabled, high impedance
// - battery: timestamp output Hi-Z, input ignored
// - battery: switch detector stays active
// - battery: irq pin active, no clock
// - supply control field layout, 7:5 unused
// - disable bit turns switch-over off
// - criterion field selects comparison source
module osc_and_supply_switch_ctrl #(
    parameter int PULSE_CYCLES = `IRQ_PULSE_CYCLES  // irq pulse length
) (
    input  wire logic                     ref_clk,        // 125 MHz clock
    input  wire logic                     rst,            // async reset
    input  wire logic [7:0]               regAddr,        // register index
    input  wire logic [7:0]               regWrData,      // write byte
    input  wire logic                     regWrEn,        // write strobe
    input  wire logic                     regRdEn,        // read strobe
    output logic [7:0]                    regRdData,      // read byte
    output logic                          regRdValid,     // read strobe
    input  wire logic                     battDetect,     // comparator pin
    input  wire logic                     irqSwitchEn,    // switch irq on
    input  wire logic                     irqLevelMode,   // 1 level, 0 pulse
    input  wire logic                     irqClkSel,      // irq pin as clock
    input  wire logic                     clkSrc,         // divided clock
    input  wire logic                     tsOutMode,      // ts pin output
    input  wire logic                     tsOutData,      // ts output level
    input  wire logic                     tsPinIn,        // ts pin level
    input  wire logic                     tsMechIn,       // switch detector
    output logic                          jitterReduceSel,// low jitter
    output osc_supply_pkg::drive_type     crystalDrive,   // decoded drive
    output osc_supply_pkg::load_type      loadCap,        // decoded load
    output logic [1:0]                    crystalDriveSel,// raw drive field
    output logic [1:0]                    loadCapSel,     // raw load field
    output logic                          switchDisable,  // switch-over off
    output logic                          refreshRate,    // refresh rate
    output logic [1:0]                    criterionSel,   // comparison mode
    output logic                          thresholdSel,   // threshold pick
    output logic                          onBattery,      // supply state
    output logic                          serialEnable,   // main domain up
    output logic                          clkPinOut,      // clock pin level
    output logic                          clkPinOe,       // clock pin enable
    output logic                          tsPinOut,       // ts pin level
    output logic                          tsPinOe,        // ts pin enable
    output logic                          tsInValue,      // ts input seen
    output logic                          tsMechValue,    // switch seen
    output logic                          irqPinOut,      // always low
    output logic                          irqPinOe        // pulls pin low
);
    import osc_supply_pkg::*;

    state_type stateReg;   // registered state
    state_type stateNext;  // next state

    // field decoders, used by the register load path; reset loads the decoded values directly
    function automatic drive_type decodeDrive(input logic [1:0] f);
        case (f)
            2'h0:    decodeDrive = DRIVE_NORMAL;
            2'h1:    decodeDrive = DRIVE_LOW;
            default: decodeDrive = DRIVE_HIGH;
        endcase
    endfunction : decodeDrive

    function automatic load_type decodeLoad(input logic [1:0] f);
        case (f)
            2'h0:    decodeLoad = LOAD_7P0;
            2'h1:    decodeLoad = LOAD_6P0;
            default: decodeLoad = LOAD_12P5;
        endcase
    endfunction : decodeLoad

    logic       battNow;     // effective battery state
    logic       toBatt;      // switch to battery event
    logic       toMain;      // switch back to main event
    logic       wrOk;        // accepted write
    logic       rdOk;        // accepted read
    logic       flagClr;     // software clear of flag

    // next-state logic
    always_comb begin
        stateNext = stateReg;
        // disabled switch-over keeps the part on main supply
        battNow = stateReg.battSync
                  & ~stateReg.supplyCtrl[`SW_DISABLE_BIT];
        toBatt  = battNow & ~stateReg.onBattery;
        toMain  = ~battNow & stateReg.onBattery;
        // serial strobes dead while the main domain is off
        wrOk    = regWrEn & ~stateReg.onBattery;
        rdOk    = regRdEn & ~stateReg.onBattery;
        flagClr = wrOk && regAddr == `FLAG_ADDR
                  && !regWrData[`SW_FLAG_BIT];

        // synchronisers: stage 1 read only by stage 2
        stateNext.battMeta   = battDetect;
        stateNext.battSync   = stateReg.battMeta;
        stateNext.tsInMeta   = tsPinIn;
        stateNext.tsInSync   = stateReg.tsInMeta;
        stateNext.tsMechMeta = tsMechIn;
        stateNext.tsMechSync = stateReg.tsMechMeta;
        stateNext.onBattery  = battNow;

        // register writes
        if (wrOk && regAddr == `OSC_CTRL_ADDR) begin
            stateNext.oscCtrl = regWrData;
        end
        if (wrOk && regAddr == `SUPPLY_CTRL_ADDR) begin
            stateNext.supplyCtrl = regWrData[4:0];
        end
        stateNext.drive = decodeDrive(
            stateNext.oscCtrl[`DRIVE_MSB:`DRIVE_LSB]);
        stateNext.load  = decodeLoad(
            stateNext.oscCtrl[`LOAD_MSB:`LOAD_LSB]);

        // sticky flag, a set in the clearing cycle wins
        if (toBatt) begin
            stateNext.switchFlag = 1'b1;
        end else if (flagClr) begin
            stateNext.switchFlag = 1'b0;
        end

        // read answers, unmapped index reads zero
        stateNext.rdValid = rdOk;
        if (rdOk) begin
            case (regAddr)
                `OSC_CTRL_ADDR:    stateNext.rdData = stateReg.oscCtrl;
                `SUPPLY_CTRL_ADDR: stateNext.rdData =
                    {3'h0, stateReg.supplyCtrl};
                `FLAG_ADDR:        stateNext.rdData =
                    {7'h00, stateReg.switchFlag};
                default:           stateNext.rdData = 8'h00;
            endcase
        end

        // pulse timer restarts on either switch direction
        if (irqSwitchEn && !irqLevelMode && (toBatt || toMain)) begin
            stateNext.pulseCnt = PULSE_CYCLES[19:0];
        end else if (stateReg.pulseCnt != 20'h00000) begin
            stateNext.pulseCnt = stateReg.pulseCnt - 20'h00001;
        end else begin
            stateNext.pulseCnt = 20'h00000;
        end

        // pins: on battery the main-domain pins go quiet
        stateNext.clkOut = clkSrc;
        stateNext.clkOe  = ~battNow;
        stateNext.tsOut  = tsOutData;
        stateNext.tsOe   = tsOutMode & ~battNow;
        stateNext.tsIn   = stateReg.tsInSync & ~tsOutMode
                           & ~battNow;
        stateNext.tsMech = stateReg.tsMechSync;

        // irq pin: level follows flag, pulse from timer, clock on main only
        if (irqSwitchEn && irqLevelMode) begin
            stateNext.irqOe = stateNext.switchFlag;
        end else if (irqSwitchEn && stateNext.pulseCnt != 20'h00000) begin
            stateNext.irqOe = 1'b1;
        end else if (irqClkSel && !battNow) begin
            stateNext.irqOe = ~clkSrc;
        end else begin
            stateNext.irqOe = 1'b0;
        end
    end

    // state register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stateReg            <= '0;
            stateReg.oscCtrl    <= `OSC_CTRL_RESET;
            stateReg.supplyCtrl <= `SUPPLY_CTRL_RESET;
            stateReg.drive      <= DRIVE_NORMAL;
            stateReg.load       <= LOAD_7P0;
        end else begin
            stateReg <= stateNext;
        end
    end

    // outputs straight from the state flops, except the tied-low irqPinOut
    assign regRdData       = stateReg.rdData;
    assign regRdValid      = stateReg.rdValid;
    assign jitterReduceSel = stateReg.oscCtrl[`JITTER_BIT];
    assign crystalDrive    = stateReg.drive;
    assign loadCap         = stateReg.load;
    assign crystalDriveSel = stateReg.oscCtrl[`DRIVE_MSB:`DRIVE_LSB];
    assign loadCapSel      = stateReg.oscCtrl[`LOAD_MSB:`LOAD_LSB];
    assign switchDisable   = stateReg.supplyCtrl[`SW_DISABLE_BIT];
    assign refreshRate     = stateReg.supplyCtrl[`SW_REFRESH_BIT];
    assign criterionSel    =
        stateReg.supplyCtrl[`SW_CRIT_MSB:`SW_CRIT_LSB];
    assign thresholdSel    = stateReg.supplyCtrl[`SW_THRESH_BIT];
    assign onBattery       = stateReg.onBattery;
    // same flop as the clock pin enable: both mean main domain powered
    assign serialEnable    = stateReg.clkOe;
    assign clkPinOut       = stateReg.clkOut;
    assign clkPinOe        = stateReg.clkOe;
    assign tsPinOut        = stateReg.tsOut;
    assign tsPinOe         = stateReg.tsOe;
    assign tsInValue       = stateReg.tsIn;
    assign tsMechValue     = stateReg.tsMech;
    assign irqPinOut       = 1'b0;  // open drain, only ever pulls low
    assign irqPinOe        = stateReg.irqOe;

    // checks
    sequence s_toBatt;
        !stateReg.onBattery ##1 stateReg.onBattery;
    endsequence

    property p_flagSet;
        @(posedge ref_clk) disable iff (rst)
        s_toBatt |-> stateReg.switchFlag;
    endproperty
    a_flagSet: assert property (p_flagSet)
        else $error("flag not set on switch to battery");

    property p_noWriteOnBatt;
        @(posedge ref_clk) disable iff (rst)
        (stateReg.onBattery && regWrEn) |=>
            $stable(stateReg.oscCtrl) && $stable(stateReg.supplyCtrl);
    endproperty
    a_noWriteOnBatt: assert property (p_noWriteOnBatt)
        else $error("register written while on battery");

    property p_noReadOnBatt;
        @(posedge ref_clk) disable iff (rst)
        (stateReg.onBattery && regRdEn) |=> !regRdValid;
    endproperty
    a_noReadOnBatt: assert property (p_noReadOnBatt)
        else $error("read answered while on battery");

    property p_clkHiZ;
        @(posedge ref_clk) disable iff (rst)
        stateReg.onBattery |-> !clkPinOe && !tsPinOe && !tsInValue;
    endproperty
    a_clkHiZ: assert property (p_clkHiZ)
        else $error("main domain pin active on battery");

    property p_mechFollows;
        @(posedge ref_clk) disable iff (rst)
        tsMechIn ##1 tsMechIn ##1 tsMechIn |=> tsMechValue;
    endproperty
    a_mechFollows: assert property (p_mechFollows)
        else $error("switch detector lost");

    property p_pulseStart;
        @(posedge ref_clk) disable iff (rst)
        // enables as seen at the edge that moved the supply state
        ($changed(stateReg.onBattery) && $past(irqSwitchEn)
         && !$past(irqLevelMode))
            |-> irqPinOe ##1 irqPinOe;
    endproperty
    a_pulseStart: assert property (p_pulseStart)
        else $error("switch pulse missing");

    property p_levelFollows;
        @(posedge ref_clk) disable iff (rst)
        // pin was registered from last cycle's mode inputs
        ($past(irqSwitchEn) && $past(irqLevelMode) && stateReg.switchFlag)
            |-> irqPinOe;
    endproperty
    a_levelFollows: assert property (p_levelFollows)
        else $error("level interrupt not asserted");

    property p_disableHolds;
        @(posedge ref_clk) disable iff (rst)
        switchDisable ##1 switchDisable |-> !onBattery;
    endproperty
    a_disableHolds: assert property (p_disableHolds)
        else $error("battery entered while switch-over disabled");

    property p_driveDecode;
        @(posedge ref_clk) disable iff (rst)
        crystalDriveSel[1] |-> crystalDrive == DRIVE_HIGH;
    endproperty
    a_driveDecode: assert property (p_driveDecode)
        else $error("drive decode wrong");

    property p_loadDecode;
        @(posedge ref_clk) disable iff (rst)
        (loadCapSel == 2'h0 |-> loadCap == LOAD_7P0)
        and (loadCapSel[1] |-> loadCap == LOAD_12P5);
    endproperty
    a_loadDecode: assert property (p_loadDecode)
        else $error("load decode wrong");

endmodule : osc_and_supply_switch_ctrl
`default_nettype wire

//--- sim/host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host side serial engine, hands single bytes to the block
module host_model (
    input  wire logic       ref_clk,    // block clock
    output logic [7:0]      regAddr,    // register index
    output logic [7:0]      regWrData,  // write byte
    output logic            regWrEn,    // write strobe
    output logic            regRdEn,    // read strobe
    input  wire logic [7:0] regRdData,  // read byte
    input  wire logic       regRdValid  // read strobe
);
    // quiet bus at time zero
    initial begin
        regAddr   = 8'h00;
        regWrData = 8'h00;
        regWrEn   = 1'b0;
        regRdEn   = 1'b0;
    end

    // released lines flip, so a stale value never looks good
    task automatic idle;
        regAddr   = ~regAddr;
        regWrData = ~regWrData;
    endtask : idle

    // one byte written, strobe held across one taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        regAddr   = a;
        regWrData = d;
        regWrEn   = 1'b1;
        @(negedge ref_clk);
        regWrEn = 1'b0;
        idle();
    endtask : wr

    // one byte read, answer taken one cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        @(negedge ref_clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge ref_clk);
        v       = regRdValid;
        d       = regRdData;
        regRdEn = 1'b0;
        idle();
    endtask : rd

    // 9.0 pF crystal fitted: load field set to 7.0 pF, rest kept
    task automatic fit_9pf;
        logic [7:0] d;
        logic       v;
        rd(8'h25, d, v);
        wr(8'h25, {d[7:2], 2'b00});
    endtask : fit_9pf
endmodule : host_model

`default_nettype wire

//--- sim/osc_and_supply_switch_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none

module osc_and_supply_switch_ctrl_test;
    import osc_supply_pkg::*;
    localparam int PULSE = 8;   // short irq pulse keeps the run brief
    logic ref_clk, rst, wrEn, rdEn, rdValid, battDetect, irqSwitchEn;
    logic irqLevelMode, irqClkSel, clkSrc, tsOutMode, tsOutData;
    logic tsPinIn, tsMechIn, jitterReduceSel, switchDisable;
    logic refreshRate, thresholdSel, onBattery, serialEnable, clkPinOe;
    logic tsPinOe, tsInValue, tsMechValue, irqPinOe, vld;
    logic [7:0] addr, wrData, rdData, rdv, n;
    logic [1:0] criterionSel, driveSel, loadSel;
    logic clkPinOut, tsPinOut, irqPinOut;
    drive_type  crystalDrive;
    load_type   loadCap;
    int error_cnt = 0;  // mismatches
    int checked   = 0;  // comparisons

    host_model host (.ref_clk(ref_clk), .regAddr(addr),
        .regWrData(wrData), .regWrEn(wrEn), .regRdEn(rdEn),
        .regRdData(rdData), .regRdValid(rdValid));

    osc_and_supply_switch_ctrl #(.PULSE_CYCLES(PULSE)) dut (
        .ref_clk(ref_clk), .rst(rst), .regAddr(addr),
        .regWrData(wrData), .regWrEn(wrEn), .regRdEn(rdEn),
        .regRdData(rdData), .regRdValid(rdValid),
        .battDetect(battDetect), .irqSwitchEn(irqSwitchEn),
        .irqLevelMode(irqLevelMode), .irqClkSel(irqClkSel),
        .clkSrc(clkSrc), .tsOutMode(tsOutMode), .tsOutData(tsOutData),
        .tsPinIn(tsPinIn), .tsMechIn(tsMechIn),
        .jitterReduceSel(jitterReduceSel), .crystalDrive(crystalDrive),
        .loadCap(loadCap), .crystalDriveSel(driveSel),
        .loadCapSel(loadSel),
        .switchDisable(switchDisable), .refreshRate(refreshRate),
        .criterionSel(criterionSel), .thresholdSel(thresholdSel),
        .onBattery(onBattery), .serialEnable(serialEnable),
        .clkPinOut(clkPinOut), .clkPinOe(clkPinOe),
        .tsPinOut(tsPinOut), .tsPinOe(tsPinOe), .tsInValue(tsInValue),
        .tsMechValue(tsMechValue), .irqPinOut(irqPinOut),
        .irqPinOe(irqPinOe));

    // free running 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // single comparison point
    task automatic chk(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // read and expect a valid answer with this byte
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rdv, vld);
        chk("rd valid", {7'h00, vld}, 8'h01);
        chk("rd data", rdv, e);
    endtask : rdchk

    // every drive and load code, readback of all eight bits
    task automatic t_osc;
        logic [7:0] v [4] = '{8'h1d, 8'h04, 8'h0a, 8'h13};
        drive_type  de;
        load_type   le;
        rdchk(8'h25, 8'h00);
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h25, v[i]);
            de = v[i][3] ? DRIVE_HIGH : v[i][2] ? DRIVE_LOW : DRIVE_NORMAL;
            le = v[i][1] ? LOAD_12P5 : v[i][0] ? LOAD_6P0 : LOAD_7P0;
            chk("jitter", {7'h00, jitterReduceSel}, {7'h00, v[i][4]});
            chk("drive", {6'h00, crystalDrive}, {6'h00, de});
            chk("load", {6'h00, loadCap}, {6'h00, le});
            chk("raw", {4'h0, driveSel, loadSel}, {4'h0, v[i][3:0]});
            rdchk(8'h25, v[i]);
        end
        host.fit_9pf();
        chk("load 9pF", {6'h00, loadCap}, {6'h00, LOAD_7P0});
    endtask : t_osc

    // field layout, unused bits, disable and criterion codes
    task automatic t_supply;
        rdchk(8'h26, 8'h00);
        host.wr(8'h26, 8'hff);
        rdchk(8'h26, 8'h1f);
        chk("fields", {5'h00, switchDisable, refreshRate, thresholdSel},
            8'h07);
        battDetect = 1'b1;
        repeat (6) @(negedge ref_clk);
        chk("disabled", {7'h00, onBattery}, 8'h00);
        for (int k = 0; k < 4; k++) begin
            host.wr(8'h26, 8'h10 | 8'(k << 1));
            chk("criterion", {6'h00, criterionSel}, 8'(k));
        end
        battDetect = 1'b0;
        host.wr(8'h26, 8'h00);
    endtask : t_supply

    // trip to battery and back, pins, refusals, pulse and flag
    task automatic t_batt;
        irqSwitchEn  = 1'b1;
        irqLevelMode = 1'b1;
        tsOutMode    = 1'b1;
        @(negedge ref_clk);
        battDetect = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk("on batt", {7'h00, onBattery}, 8'h01);
        chk("serial", {7'h00, serialEnable}, 8'h00);
        chk("clk oe", {7'h00, clkPinOe}, 8'h00);
        chk("ts oe", {7'h00, tsPinOe}, 8'h00);
        chk("irq lvl", {7'h00, irqPinOe}, 8'h01);
        host.wr(8'h25, 8'hff);
        host.rd(8'h2b, rdv, vld);
        chk("rd refused", {7'h00, vld}, 8'h00);
        tsOutMode = 1'b0;
        tsPinIn   = 1'b1;
        tsMechIn  = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("ts in", {7'h00, tsInValue}, 8'h00);
        chk("ts mech", {7'h00, tsMechValue}, 8'h01);
        irqLevelMode = 1'b0;
        irqClkSel    = 1'b1;
        repeat (6) begin
            @(negedge ref_clk);
            chk("irq clk", {7'h00, irqPinOe}, 8'h00);
            clkSrc = ~clkSrc;
        end
        // six toggles already left clkSrc low
        irqClkSel = 1'b0;
        tsOutMode = 1'b1;
        battDetect = 1'b0;
        n = 8'h00;
        repeat (20) begin
            @(negedge ref_clk);
            n = n + {7'h00, irqPinOe};
        end
        chk("pulse len", n, 8'(PULSE));
        chk("serial", {7'h00, serialEnable}, 8'h01);
        chk("ts oe", {7'h00, tsPinOe}, 8'h01);
        rdchk(8'h25, 8'h10);
        rdchk(8'h2b, 8'h01);
        host.wr(8'h2b, 8'h00);
        rdchk(8'h2b, 8'h00);
    endtask : t_batt

    // main pins, irq clock, pulse on entry, enable off, ts input back
    task automatic t_pulse;
        irqClkSel = 1'b1;
        clkSrc    = 1'b1;
        @(negedge ref_clk);
        chk("clk pin", {7'h00, clkPinOut}, 8'h01);
        chk("ts pin", {7'h00, tsPinOut}, 8'h01);
        chk("irq pin", {7'h00, irqPinOut}, 8'h00);
        chk("irq clk hi", {7'h00, irqPinOe}, 8'h00);
        clkSrc = 1'b0;
        @(negedge ref_clk);
        chk("irq clk lo", {7'h00, irqPinOe}, 8'h01);
        irqClkSel  = 1'b0;
        battDetect = 1'b1;
        n = 8'h00;
        repeat (20) begin
            @(negedge ref_clk);
            n = n + {7'h00, irqPinOe};
        end
        chk("pulse in", n, 8'(PULSE));
        chk("on batt 2", {7'h00, onBattery}, 8'h01);
        irqSwitchEn = 1'b0;
        battDetect  = 1'b0;
        n = 8'h00;
        repeat (20) begin
            @(negedge ref_clk);
            n = n + {7'h00, irqPinOe};
        end
        chk("irq off", n, 8'h00);
        rdchk(8'h2b, 8'h01);
        host.wr(8'h2b, 8'h00);
        tsOutMode = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("ts in main", {7'h00, tsInValue}, 8'h01);
    endtask : t_pulse

    // counts, verdict, end of run
    task automatic stop_test;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    // main sequence
    initial begin
        {rst, battDetect, irqSwitchEn, irqLevelMode, irqClkSel} = 5'h10;
        {clkSrc, tsOutMode, tsOutData, tsPinIn, tsMechIn} = 5'h04;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        t_osc();
        t_supply();
        t_batt();
        t_pulse();
        stop_test();
    end

    // hang guard, run needs well under a thousand cycles
    initial begin
        #50000;
        error_cnt++;
        stop_test();
    end
endmodule : osc_and_supply_switch_ctrl_test

`default_nettype wire
